// ### verilog/rfh_pkg.sv
// Purpose: shared constants and types for the receive fragment framer
// Assumes: one byte enters per cycle at most; 32-bit output words
// Notes:   header layout and error code encodings live here
package rfh_pkg;

    // ****************************************************************
    // sizes
    // ****************************************************************
    localparam int CH_W      = 11;         // channel number width
    localparam int NUM_CH    = 2048;       // logical channels
    localparam int LEN_W     = 10;         // payload byte count width
    localparam int BUF_DEPTH = 1024;       // payload bytes per buffer
    localparam int ADDR_W    = 10;         // buffer address width

    // ****************************************************************
    // header field positions
    // ****************************************************************
    localparam int HDR_RSV_HI = 31;        // reserved top
    localparam int HDR_RSV_LO = 27;
    localparam int HDR_CH_HI  = 26;        // channel number
    localparam int HDR_CH_LO  = 16;
    localparam int HDR_ERR_HI = 15;        // message error code
    localparam int HDR_ERR_LO = 12;
    localparam int HDR_FIRST  = 11;        // first fragment flag
    localparam int HDR_LAST   = 10;        // last fragment flag
    localparam int HDR_LEN_HI = 9;         // payload byte count
    localparam int HDR_LEN_LO = 0;
    localparam logic [4:0] RSV_VAL = 5'h00;

    // ****************************************************************
    // message error codes
    // ****************************************************************
    localparam logic [3:0] ERR_NONE   = 4'h0;
    localparam logic [3:0] ERR_OVFL   = 4'h1;
    localparam logic [3:0] ERR_FRM_CHG  = 4'h2;
    localparam logic [3:0] ERR_NO_FRAME = 4'h3;
    localparam logic [3:0] ERR_ABORT  = 4'h4;
    localparam logic [3:0] ERR_LONG   = 4'h5;
    localparam logic [3:0] ERR_ALIGN  = 4'h6;
    localparam logic [3:0] ERR_FCS    = 4'h7;

    localparam logic [LEN_W-1:0] LEN_ZERO = 10'h000;
    localparam logic [LEN_W-1:0] LEN_ONE  = 10'h001;
    localparam logic [1:0]       LANE_ZERO = 2'h0;
    localparam logic [1:0]       LANE_LAST = 2'h3;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic              valid;          // beat present this cycle
        logic [CH_W-1:0]   channel;        // owning channel
        logic [7:0]        data;           // payload byte
        logic              eom;            // byte (or none) ends message
        logic              eom_only;       // end marker carries no byte
        logic              overflow;       // condition flags at end
        logic              frame_alignment_change;
        logic              out_of_frame;
        logic              abort;
        logic              too_long;
        logic              misaligned;
        logic              fcs_bad;
    } rfh_rx_t;

    typedef struct packed {
        logic        valid;                // word valid
        logic        sop;                  // header word
        logic        eop;                  // last word of fragment
        logic [31:0] data;
    } rfh_word_t;

    typedef enum logic [1:0] {
        ST_FILL = 2'b00,                   // collecting bytes
        ST_HDR  = 2'b01,                   // header word on bus
        ST_PAY  = 2'b10                    // payload words on bus
    } rfh_state_t;

endpackage

// ### verilog/rfh_byte_mem.sv
// Purpose: payload byte store for one fragment under assembly
// Assumes: single writer, single reader, same clock
// Notes:   read data is registered, one cycle after address
`timescale 1ns/1ps
module rfh_byte_mem (
    input  wire logic                        clk_i,
    input  wire logic                        we_i,
    input  wire logic [rfh_pkg::ADDR_W-1:0]  waddr_i,
    input  wire logic [7:0]                  wdata_i,
    input  wire logic [rfh_pkg::ADDR_W-1:0]  raddr_i,
    output logic      [7:0]                  rdata_o
);
    import rfh_pkg::*;

    // ****************************************************************
    // storage
    // ****************************************************************
    logic [7:0] mem [BUF_DEPTH];           // no reset: data only

    // write port and registered read port
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end

endmodule

// ### verilog/rfh_framer.sv
// Purpose: receive fragmenter, header plus payload on 32-bit word bus
// Assumes: byte source and word sink on SYS_CLK_I; sink may stall
// Notes:   one fragment assembled at a time; source stalls while it drains
//
// Summary of operation
// - buffer bytes; close on message end or size
// - header word precedes payload words, 32 bits
// - middle fragments full size; last may be empty
// - error code 0 none, 1 overflow
// - error code 2 on frame alignment change
// - error code 3 on out of frame
// - error code 4 on abort
// - error code 5 on too long message
// - error code 6 on misaligned bit count
// - error code 7 on check sequence mismatch
// - first fragment flag only on first
// - last fragment flag; error valid only then
// - byte count of payload in low bits
// - non-last fragments carry maximum count
`timescale 1ns/1ps
module rfh_framer (
    input  wire logic                       SYS_CLK_I,
    input  wire logic                       RST_N_I,
    input  wire logic [rfh_pkg::LEN_W-1:0]  FRAG_SIZE_I,
    input  wire rfh_pkg::rfh_rx_t           RX_I,
    output rfh_pkg::rfh_word_t              WORD_O,
    input  wire logic                       WORD_READY_I,
    output logic                            RX_READY_O
);
    import rfh_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    rfh_state_t          state_reg, state_next;      // main sequence
    logic [LEN_W-1:0]    count_reg, count_next;      // bytes held
    logic [CH_W-1:0]     chan_reg, chan_next;        // fragment channel
    logic                last_reg, last_next;        // fragment ends msg
    logic [3:0]          err_reg, err_next;          // latched code
    logic [LEN_W-1:0]    size_reg, size_next;        // size at close
    logic [LEN_W-1:0]    rptr_reg, rptr_next;        // read position
    logic [1:0]          lane_reg, lane_next;        // byte lane
    logic [31:0]         acc_reg, acc_next;          // word assembly
    logic                rd_pend_reg, rd_pend_next;  // mem data due
    logic [NUM_CH-1:0]   mid_msg_reg;                // not at message start
    rfh_word_t           word_reg, word_next;        // output word
    logic                rx_rdy_reg, rx_rdy_next;    // source may send
    logic [7:0]          mem_rdata;                  // buffer read data

    // ****************************************************************
    // decoding
    // ****************************************************************
    // highest listed condition wins when several occurred
    function automatic logic [3:0] err_code(input rfh_rx_t r);
        if      (r.fcs_bad)            return ERR_FCS;
        else if (r.misaligned)         return ERR_ALIGN;
        else if (r.too_long)           return ERR_LONG;
        else if (r.abort)              return ERR_ABORT;
        else if (r.out_of_frame)       return ERR_NO_FRAME;
        else if (r.frame_alignment_change) return ERR_FRM_CHG;
        else if (r.overflow)           return ERR_OVFL;
        else                           return ERR_NONE;
    endfunction

    wire rx_take   = RX_I.valid && rx_rdy_reg;        // accepted this cycle
    wire rx_byte   = rx_take && !RX_I.eom_only;       // carries a byte
    wire [LEN_W-1:0] cnt_inc = count_reg + LEN_ONE;
    // zero size would never close; treat as one byte
    wire [LEN_W-1:0] frag_lim = (FRAG_SIZE_I == LEN_ZERO) ? LEN_ONE
                                                         : FRAG_SIZE_I;
    wire size_hit  = rx_byte && (cnt_inc == frag_lim);
    wire close_now = rx_take && (RX_I.eom || size_hit);
    wire first_frag = !mid_msg_reg[chan_reg];
    wire sink_free = !word_reg.valid || WORD_READY_I;
    wire pay_done  = (rptr_reg == size_reg) && !rd_pend_reg;

    // header assembly: reserved zero, channel, code, flags, count
    wire [31:0] header = {RSV_VAL,
                          chan_reg,
                          last_reg ? err_reg : ERR_NONE,
                          first_frag,
                          last_reg,
                          size_reg};

    // ****************************************************************
    // byte buffer
    // ****************************************************************
    rfh_byte_mem u_mem (
        .clk_i   (SYS_CLK_I),
        .we_i    (rx_byte),
        .waddr_i (count_reg),
        .wdata_i (RX_I.data),
        .raddr_i (rptr_reg),
        .rdata_o (mem_rdata)
    );

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        state_next   = state_reg;
        count_next   = count_reg;
        chan_next    = chan_reg;
        last_next    = last_reg;
        err_next     = err_reg;
        size_next    = size_reg;
        rptr_next    = rptr_reg;
        lane_next    = lane_reg;
        acc_next     = acc_reg;
        rd_pend_next = 1'b0;
        rx_rdy_next  = rx_rdy_reg;
        word_next    = word_reg;
        if (word_reg.valid && WORD_READY_I) begin
            word_next.valid = 1'b0;        // word taken by sink
        end
        unique case (state_reg)
            ST_FILL: begin
                if (rx_byte) begin
                    count_next = cnt_inc;
                end
                if (rx_take) begin
                    chan_next = RX_I.channel;  // channel of fragment
                end
                if (close_now) begin
                    // stall source while this fragment drains
                    rx_rdy_next = 1'b0;
                    last_next   = RX_I.eom;
                    err_next    = err_code(RX_I);
                    size_next   = rx_byte ? cnt_inc : count_reg;
                    state_next  = ST_HDR;
                end
            end
            ST_HDR: begin
                if (sink_free) begin
                    word_next  = '{valid: 1'b1, sop: 1'b1,
                                   eop: (size_reg == LEN_ZERO),
                                   data: header};
                    rptr_next  = LEN_ZERO;
                    lane_next  = LANE_ZERO;
                    acc_next   = '0;
                    state_next = ST_PAY;
                end
            end
            ST_PAY: begin
                // issue read only when sink free; packing next cycle writes word_next without checking the sink
                if (rptr_reg != size_reg && !rd_pend_reg && sink_free) begin
                    rptr_next    = rptr_reg + LEN_ONE;
                    rd_pend_next = 1'b1;
                end
                if (rd_pend_reg) begin
                    // first byte goes to the top lane
                    acc_next = {acc_reg[23:0], mem_rdata};
                    lane_next = lane_reg + 2'h1;
                    if (lane_reg == LANE_LAST || rptr_reg == size_reg) begin
                        // short tail word is left-justified
                        word_next = '{valid: 1'b1, sop: 1'b0,
                                      eop: (rptr_reg == size_reg),
                                      data: {acc_reg[23:0], mem_rdata}
                                            << {~lane_reg, 3'b000}};
                        lane_next = LANE_ZERO;
                        acc_next  = '0;
                    end
                end
                if (pay_done && sink_free && !word_next.valid
                    || (size_reg == LEN_ZERO && sink_free)) begin
                    count_next  = LEN_ZERO;
                    rx_rdy_next = 1'b1;
                    state_next  = ST_FILL;
                end
            end
            default: begin
                state_next = ST_FILL;
            end
        endcase
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_reg   <= ST_FILL;
            count_reg   <= LEN_ZERO;
            chan_reg    <= '0;
            last_reg    <= 1'b0;
            err_reg     <= ERR_NONE;
            size_reg    <= LEN_ZERO;
            rptr_reg    <= LEN_ZERO;
            lane_reg    <= LANE_ZERO;
            acc_reg     <= '0;
            rd_pend_reg <= 1'b0;
            word_reg    <= '0;
            rx_rdy_reg  <= 1'b1;
        end else begin
            state_reg   <= state_next;
            count_reg   <= count_next;
            chan_reg    <= chan_next;
            last_reg    <= last_next;
            err_reg     <= err_next;
            size_reg    <= size_next;
            rptr_reg    <= rptr_next;
            lane_reg    <= lane_next;
            acc_reg     <= acc_next;
            rd_pend_reg <= rd_pend_next;
            word_reg    <= word_next;
            rx_rdy_reg  <= rx_rdy_next;
        end
    end

    // per-channel message position, updated when header goes out
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            mid_msg_reg <= '0;
        end else if (state_reg == ST_HDR && sink_free) begin
            mid_msg_reg[chan_reg] <= !last_reg;
        end
    end

    assign WORD_O     = word_reg;
    assign RX_READY_O = rx_rdy_reg;

endmodule

// ### dv/rfh_framer_props.sv
// Purpose: port checker for the receive fragment framer
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound into every framer instance
`timescale 1ns/1ps
module rfh_framer_props (
    input  wire logic                      SYS_CLK_I,
    input  wire logic                      RST_N_I,
    input  wire logic [rfh_pkg::LEN_W-1:0] FRAG_SIZE_I,
    input  wire rfh_pkg::rfh_rx_t          RX_I,
    input  wire rfh_pkg::rfh_word_t        WORD_O,
    input  wire logic                      WORD_READY_I,
    input  wire logic                      RX_READY_O
);
    import rfh_pkg::*;
    // ****************************************************************
    // helpers
    // ****************************************************************
    logic [LEN_W-1:0] full_len;            // zero size acts as one
    logic             hdr;                 // header word on bus
    assign full_len = (FRAG_SIZE_I == LEN_ZERO) ? LEN_ONE : FRAG_SIZE_I;
    assign hdr      = WORD_O.valid && WORD_O.sop;
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!RST_N_I);
    sequence s_close;                      // message end taken
        RX_I.valid && RX_READY_O && RX_I.eom;
    endsequence
    sequence s_hdr_out;                    // header word shown
        WORD_O.valid && WORD_O.sop;
    endsequence
    // ****************************************************************
    // properties
    // ****************************************************************
    chk_hdr_follows: assert property (s_close |-> ##2 s_hdr_out)
        else $error("header late after message end");
    chk_rx_stall: assert property (s_close |=> !RX_READY_O [*2])
        else $error("source not stalled after close");
    chk_ready_back: assert property (
        WORD_O.valid && WORD_O.eop && WORD_READY_I |=> RX_READY_O)
        else $error("source not released after drain");
    chk_word_hold: assert property (
        WORD_O.valid && !WORD_READY_I |=> WORD_O.valid && $stable(WORD_O))
        else $error("word changed before taken");
    chk_rsv_zero: assert property (
        hdr |-> WORD_O.data[31:27] == RSV_VAL)
        else $error("reserved header bits set");
    chk_err_gated: assert property (
        hdr && !WORD_O.data[10] |-> WORD_O.data[15:12] == ERR_NONE)
        else $error("error code on non-last fragment");
    chk_full_count: assert property (
        hdr && !WORD_O.data[10] |-> WORD_O.data[9:0] == full_len)
        else $error("non-last fragment not full");
    chk_len_bound: assert property (
        hdr |-> WORD_O.data[9:0] <= full_len)
        else $error("fragment longer than size");
    chk_empty_eop: assert property (
        hdr && WORD_O.data[10] && WORD_O.data[9:0] == LEN_ZERO
        |-> WORD_O.eop)
        else $error("empty fragment header not final word");
endmodule
bind rfh_framer rfh_framer_props chk_u (
    .SYS_CLK_I    (SYS_CLK_I),
    .RST_N_I      (RST_N_I),
    .FRAG_SIZE_I  (FRAG_SIZE_I),
    .RX_I         (RX_I),
    .WORD_O       (WORD_O),
    .WORD_READY_I (WORD_READY_I),
    .RX_READY_O   (RX_READY_O)
);

// ### dv/rfh_sink.sv
// Purpose: system side packet processor taking framer words
// Assumes: same clock as the framer
// Notes:   slow mode stalls every other cycle
`timescale 1ns/1ps
module rfh_sink (
    input  wire logic               clk_i,
    input  wire logic               rst_n_i,
    input  wire rfh_pkg::rfh_word_t word_i,
    input  wire logic               slow_i,
    output logic                    ready_o,
    output logic [3:0]              msg_err_o,
    output logic                    len_bad_o
);
    import rfh_pkg::*;
    logic [LEN_W-1:0] left_reg;            // payload bytes still owed
    // ****************************************************************
    // accept words, track header fields
    // ****************************************************************
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ready_o   <= 1'b0;
            left_reg  <= LEN_ZERO;
            msg_err_o <= ERR_NONE;
            len_bad_o <= 1'b0;
        end else begin
            ready_o <= slow_i ? !ready_o : 1'b1;
            if (word_i.valid && ready_o && word_i.sop) begin
                // new header while payload still owed
                if (left_reg != LEN_ZERO) begin
                    len_bad_o <= 1'b1;
                end
                left_reg <= word_i.data[9:0];
                if (word_i.data[10]) begin
                    // status ignored unless last
                    msg_err_o <= word_i.data[15:12];
                end
            end else if (word_i.valid && ready_o) begin
                // payload beyond the advertised count is a fault
                if (left_reg == LEN_ZERO) begin
                    len_bad_o <= 1'b1;
                end
                left_reg <= (left_reg > 10'h004) ? left_reg - 10'h004 : '0;
            end
        end
    end
endmodule

// ### dv/rfh_framer_tb.sv
// Purpose: self-checking bench for the receive fragment framer
// Assumes: inputs driven 5 ns after each rising edge
// Notes:   expected words built from the header layout
`timescale 1ns/1ps
module rfh_framer_tb;
    import rfh_pkg::*;
    logic             sys_clk, rst_n, slow, word_ready;
    logic [LEN_W-1:0] frag_size;           // fragment size input
    rfh_rx_t          rx;                  // byte source beat
    rfh_word_t        word;                // framer output
    logic             rx_ready;
    logic [3:0]       sink_err;            // status seen by sink
    logic             sink_len_bad;        // sink saw count mismatch
    rfh_word_t        got[$], exp[$];      // taken and expected
    int               n_errors, cmp_count, cycles;
    initial sys_clk = 1'b0;
    always #25 sys_clk = ~sys_clk;
    rfh_framer dut_u (.SYS_CLK_I(sys_clk), .RST_N_I(rst_n),
        .FRAG_SIZE_I(frag_size), .RX_I(rx), .WORD_O(word),
        .WORD_READY_I(word_ready), .RX_READY_O(rx_ready));
    rfh_sink sink_u (.clk_i(sys_clk), .rst_n_i(rst_n), .word_i(word),
        .slow_i(slow), .ready_o(word_ready), .msg_err_o(sink_err),
        .len_bad_o(sink_len_bad));
    // ****************************************************************
    // capture taken words; hang guard
    // ****************************************************************
    always @(posedge sys_clk) begin
        cycles++;
        if (word.valid && word_ready) got.push_back(word);
        if (cycles == 20000) begin
            n_errors++;
            end_of_test();
        end
    end
    task automatic check(string what, logic [34:0] e, logic [34:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    // one beat, held until the framer takes it
    task automatic put_beat(logic [CH_W-1:0] ch, logic [7:0] d,
                            logic eom, logic only, logic [6:0] fl);
        rfh_rx_t b;
        b = '0;
        {b.valid, b.channel, b.data} = {1'b1, ch, d};
        {b.eom, b.eom_only} = {eom, only};
        {b.overflow, b.frame_alignment_change, b.out_of_frame, b.abort,
         b.too_long, b.misaligned, b.fcs_bad} = fl;
        rx = b;
        while (!rx_ready) begin
            @(posedge sys_clk);
            #5;
        end
        @(posedge sys_clk);
        #5;
    endtask
    // send a message, build its fragments, compare after drain
    task automatic send_msg(logic [CH_W-1:0] ch, int n, bit zb,
                            logic [3:0] code);
        int r, len, s, p;
        logic first, last;
        logic [31:0] w;
        logic [6:0] fl;
        s = (frag_size == LEN_ZERO) ? 1 : int'(frag_size);
        fl = (code == ERR_NONE) ? 7'h00 : 7'h40 >> (code - 4'h1);
        r = n;
        first = 1'b1;
        p = 0;
        do begin
            last = zb ? (r < s) : (r <= s);
            len = last ? r : s;
            exp.push_back({1'b1, 1'b1, len == 0, 5'h00, ch,
                last ? code : ERR_NONE, first, last, 10'(len)});
            for (int i = 0; i < len; i += 4) begin
                w = '0;
                for (int j = 0; j < 4 && i + j < len; j++)
                    w[31 - 8 * j -: 8] = 8'(ch + p + i + j);
                exp.push_back({1'b1, 1'b0, i + 4 >= len, w});
            end
            p += len;
            r -= len;
            first = 1'b0;
        end while (!last);
        for (int i = 0; i < n; i++)
            put_beat(ch, 8'(ch + i), !zb && i == n - 1, 1'b0,
                     (!zb && i == n - 1) ? fl : 7'h00);
        if (zb) put_beat(ch, 8'h00, 1'b1, 1'b1, fl);
        rx = '0;
        for (int t = 0; t < 3000; t++) begin
            if (got.size() >= exp.size() && rx_ready) break;
            @(posedge sys_clk);
            #5;
        end
        check("word count", 35'(exp.size()), 35'(got.size()));
        for (int i = 0; i < exp.size() && i < got.size(); i++)
            check("word", exp[i], got[i]);
        check("sink status", 35'(code), 35'(sink_err));
        check("sink length", 35'h0, 35'(sink_len_bad));
        got.delete();
        exp.delete();
    endtask
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        {rst_n, slow, n_errors, cmp_count, cycles} = '0;
        rx = '0;
        frag_size = 10'h004;
        repeat (10) @(posedge sys_clk);
        #5;
        rst_n = 1'b1;
        check("ready after reset", 35'h1, 35'(rx_ready));
        check("word after reset", 35'h0, 35'(word));
        send_msg(11'h005, 10, 1'b0, ERR_NONE);
        $display("test multi fragment done");
        send_msg(11'h00a, 4, 1'b1, ERR_NONE);
        $display("test empty last fragment done");
        frag_size = 10'h005;
        slow = 1'b1;
        send_msg(11'h123, 12, 1'b0, ERR_FCS);
        $display("test resized stalled done");
        for (int c = 1; c < 8; c++) begin
            send_msg(11'h7ff, 3, 1'b0, 4'(c));
        end
        $display("test error codes done");
        // zero size acts as one byte per fragment
        frag_size = 10'h000;
        send_msg(11'h040, 2, 1'b0, ERR_NONE);
        $display("test zero size done");
        end_of_test();
    end
endmodule
